// ### pkg/cps_regs.vh
`ifndef CPS_REGS_VH
`define CPS_REGS_VH
// Overview of operation
// - Eight-bit accumulator holds operands and takes arithmetic and logic results.
// - Sixteen-bit index register is upper byte joined to lower byte.
// - Any reset sets the stack pointer to 00FF.
// - Reset-stack-low instruction sets stack low byte to FF, high byte kept.
// - Stack pointer names next free slot; push decrements, pull increments.
// - Program pointer steps on each fetch; jumps, branches, interrupts load it.
// - Leaving reset, program pointer loads vector at FFFE high, FFFF low.
// - Flags register holds mask plus five flags; bits 6 and 5 read one.
// - Overflow flag set on two's complement overflow, else cleared.
// - Half-carry set on carry from bit 3 to 4 during adds.
// - Mask set ignores maskable requests; mask clear accepts them.
// - Interrupt entry pushes registers, then sets mask, then fetches vector.
// - Interrupt entry never pushes the index high byte; software saves it.
// - Reset sets mask; clear-mask, wait and stop clear it; return restores it.
// - With several requests pending, highest priority is served first.
// - Negative flag takes bit 7 of the result.
// - Zero flag set when the result is 00, else cleared.
// - Carry set on carry out of bit 7 or borrow; shifts write it.
// - Wait clears mask, stops clock; interrupt exit keeps mask clear.
// - Stop clears mask, stops clock; clock restarts after stabilisation delay.
// - Break loads trap opcode and vector FFFC, or FEFC in monitor mode.
// - Break starts after current instruction; return ends it only if released.

// Register byte offsets
`define CPS_ADR_CMD 5'h00
`define CPS_ADR_ACC 5'h04
`define CPS_ADR_HX 5'h08
`define CPS_ADR_SP 5'h0C
`define CPS_ADR_PC 5'h10
`define CPS_ADR_CCR 5'h14
`define CPS_ADR_STAT 5'h18

// Flags register bit positions
`define CPS_CCR_C 0
`define CPS_CCR_Z 1
`define CPS_CCR_N 2
`define CPS_CCR_I 3
`define CPS_CCR_H 4
`define CPS_CCR_V 7
`define CPS_CCR_ONES 8'h60
`define CPS_CCR_RESET 8'h68

// Reset values and vectors
`define CPS_SP_RESET 16'h00FF
`define CPS_SP_LOW_FILL 8'hFF
`define CPS_VEC_RESET 16'hFFFE
`define CPS_VEC_TRAP 16'hFFFC
`define CPS_VEC_TRAP_MON 16'hFEFC
`define CPS_VEC_IRQ0 16'hFFFA

// Command opcodes, CMD[12:8]
`define CPS_OP_LDA 5'h00
`define CPS_OP_ADD 5'h01
`define CPS_OP_ADC 5'h02
`define CPS_OP_SUB 5'h03
`define CPS_OP_SBC 5'h04
`define CPS_OP_AND 5'h05
`define CPS_OP_ORA 5'h06
`define CPS_OP_EOR 5'h07
`define CPS_OP_ASL 5'h08
`define CPS_OP_LDX 5'h09
`define CPS_OP_LDH 5'h0A
`define CPS_OP_STK_LOW 5'h0B
`define CPS_OP_PSHA 5'h0C
`define CPS_OP_PULA 5'h0D
`define CPS_OP_PUSH_HI 5'h0E
`define CPS_OP_PULL_HI 5'h0F
`define CPS_OP_MASK_CLR 5'h10
`define CPS_OP_SEI 5'h11
`define CPS_OP_JMP 5'h12
`define CPS_OP_FETCH 5'h13
`define CPS_OP_BRA 5'h14
`define CPS_OP_RET_INT 5'h15
`define CPS_OP_TRAP 5'h16
`define CPS_OP_WAIT 5'h17
`define CPS_OP_STOP 5'h18
`endif

// ### src/cps_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module cps_alu (
  // Operation and operands
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] m,
  input wire [7:0] ccr_in,
  // Results
  output reg [7:0] res,
  output reg [7:0] ccr_out
);
  reg [8:0] wide;
  reg [4:0] half;
  reg cin;
  always @* begin
    cin = ccr_in[`CPS_CCR_C];
    wide = 9'h000;
    half = 5'h00;
    res = m;
    ccr_out = ccr_in;
    case (op)
      4'h1, 4'h2: begin
        if (op == 4'h1) begin
          cin = 1'b0;
        end
        wide = {1'b0, a} + {1'b0, m} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        res = wide[7:0];
        ccr_out[`CPS_CCR_H] = half[4];
        ccr_out[`CPS_CCR_C] = wide[8];
        ccr_out[`CPS_CCR_V] = (a[7] == m[7]) && (res[7] != a[7]);
      end
      4'h3, 4'h4: begin
        if (op == 4'h3) begin
          cin = 1'b0;
        end
        wide = {1'b0, a} - {1'b0, m} - {8'h00, cin};
        res = wide[7:0];
        ccr_out[`CPS_CCR_C] = wide[8];
        ccr_out[`CPS_CCR_V] = (a[7] != m[7]) && (res[7] != a[7]);
      end
      4'h5, 4'h6, 4'h7: begin
        res = (op == 4'h5) ? (a & m) : ((op == 4'h6) ? (a | m) : (a ^ m));
        ccr_out[`CPS_CCR_V] = 1'b0;
      end
      4'h8: begin
        res = {a[6:0], 1'b0};
        ccr_out[`CPS_CCR_C] = a[7];
        ccr_out[`CPS_CCR_V] = a[7] ^ a[6];
      end
      default: begin
        ccr_out[`CPS_CCR_V] = 1'b0;
      end
    endcase
    ccr_out[`CPS_CCR_N] = res[7];
    ccr_out[`CPS_CCR_Z] = (res == 8'h00);
  end
endmodule
`default_nettype wire

// ### src/cps_wb.v
`timescale 1ns/1ps
`default_nettype none
module cps_wb (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Wishbone request
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  // Answer
  input wire [31:0] rd_data,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wr_stb
);
  reg ack_reg;
  reg [31:0] dat_reg;
  wire req = wb_cyc_i && wb_stb_i;
  // One wait state; ack drops in the cycle after it was given
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rd_data;
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  // Write lands on the edge where the master sees ack
  assign wr_stb = req && wb_we_i && ack_reg;
endmodule
`default_nettype wire

// ### src/cps_core.v
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module cps_core #(
  parameter IRQ_N = 4,
  parameter STAB_CYCLES = 4096,
  // Arbitrary value, set per product
  parameter [7:0] TRAP_OPCODE = 8'h00
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Memory bus
  output wire [15:0] mem_addr,
  output wire mem_rd,
  output wire mem_wr,
  output wire [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  // Interrupt and break requests
  input wire [IRQ_N-1:0] irq_req,
  input wire ext_irq_b,
  input wire brk_req,
  input wire monitor_mode,
  // Core control
  output wire cpu_clk_en,
  output wire ir_load,
  output wire [7:0] ir_value
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_VECT = 3'h1;
  localparam [2:0] ST_PUSH = 3'h2;
  localparam [2:0] ST_SETI = 3'h3;
  localparam [2:0] ST_PULL = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_STAB = 3'h6;
  localparam [1:0] PL_FRAME = 2'h0;
  localparam [1:0] PL_ACC = 2'h1;
  localparam [1:0] PL_HIGH = 2'h2;
  localparam [31:0] STAB_LAST = STAB_CYCLES - 1;

  reg [7:0] acc_reg;
  reg [15:0] hx_reg;
  reg [15:0] sp_reg;
  reg [15:0] pc_reg;
  reg [7:0] ccr_reg;
  reg [2:0] state_reg;
  reg [2:0] cnt_reg;
  reg [15:0] vec_base_reg;
  reg [1:0] pull_sel_reg;
  reg [2:0] pull_len_reg;
  reg stop_mode_reg;
  reg brk_active_reg;
  reg ir_load_reg;
  reg [7:0] ir_value_reg;
  reg [15:0] mem_addr_reg;
  reg mem_rd_reg;
  reg mem_wr_reg;
  reg [7:0] mem_wdata_reg;
  reg [31:0] stab_cnt_reg;
  reg ext_s1_reg;
  reg ext_s2_reg;

  // External interrupt pin is asynchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
    end else begin
      ext_s1_reg <= ext_irq_b;
      ext_s2_reg <= ext_s1_reg;
    end
  end
  wire ext_irq = ~ext_s2_reg;
  wire [IRQ_N:0] req_all = {irq_req, ext_irq};

  reg [3:0] req_idx;
  reg req_any;
  integer i;
  always @* begin
    req_idx = 4'h0;
    req_any = 1'b0;
    for (i = IRQ_N; i >= 0; i = i - 1) begin
      if (req_all[i]) begin
        req_idx = i[3:0];
        req_any = 1'b1;
      end
    end
  end

  // bits 6 and 5 always one
  wire [7:0] ccr_view = ccr_reg | `CPS_CCR_ONES;
  wire [15:0] irq_vec = `CPS_VEC_IRQ0 - {11'h000, req_idx, 1'b0};
  wire [15:0] sp_up = sp_reg + 16'h0001;
  wire [15:0] sp_down = sp_reg - 16'h0001;

  wire wr_stb;
  reg [31:0] rd_data;
  cps_wb u_wb (
    .clk(clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .rd_data(rd_data),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wr_stb(wr_stb)
  );

  // Commands while busy are dropped; status bit 0 tells software
  wire [4:0] cmd_op = wb_dat_i[12:8];
  wire [7:0] cmd_data = wb_dat_i[7:0];
  wire cmd_go = wr_stb && (wb_adr_i == `CPS_ADR_CMD) && (&wb_sel_i[1:0]) && (state_reg == ST_IDLE);

  always @* begin
    case (wb_adr_i)
      `CPS_ADR_ACC: rd_data = {24'h000000, acc_reg};
      `CPS_ADR_HX: rd_data = {16'h0000, hx_reg};
      `CPS_ADR_SP: rd_data = {16'h0000, sp_reg};
      `CPS_ADR_PC: rd_data = {16'h0000, pc_reg};
      `CPS_ADR_CCR: rd_data = {24'h000000, ccr_view};
      `CPS_ADR_STAT: rd_data = {25'h0000000, state_reg, brk_active_reg, stop_mode_reg,
                                cpu_clk_en, state_reg != ST_IDLE};
      default: rd_data = 32'h00000000;
    endcase
  end

  wire [7:0] alu_res;
  wire [7:0] alu_ccr;
  cps_alu u_alu (
    .op(cmd_op[3:0]),
    .a(acc_reg),
    .m(cmd_data),
    .ccr_in(ccr_reg),
    .res(alu_res),
    .ccr_out(alu_ccr)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= 8'h00;
      hx_reg <= 16'h0000;
      sp_reg <= `CPS_SP_RESET;
      pc_reg <= 16'h0000;
      ccr_reg <= `CPS_CCR_RESET;
      state_reg <= ST_VECT;
      vec_base_reg <= `CPS_VEC_RESET;
      cnt_reg <= 3'h0;
      pull_sel_reg <= PL_FRAME;
      pull_len_reg <= 3'h0;
      stop_mode_reg <= 1'b0;
      brk_active_reg <= 1'b0;
      ir_load_reg <= 1'b0;
      ir_value_reg <= 8'h00;
      mem_addr_reg <= 16'h0000;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      stab_cnt_reg <= 32'h00000000;
    end else begin
      ir_load_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          mem_wr_reg <= 1'b0;
          if (cmd_go) begin
            if (cmd_op <= `CPS_OP_ASL) begin
              acc_reg <= alu_res;
              ccr_reg <= alu_ccr;
            end
            case (cmd_op)
              `CPS_OP_LDX: hx_reg[7:0] <= cmd_data;
              `CPS_OP_LDH: hx_reg[15:8] <= cmd_data;
              `CPS_OP_STK_LOW: sp_reg[7:0] <= `CPS_SP_LOW_FILL;
              `CPS_OP_PSHA, `CPS_OP_PUSH_HI: begin
                mem_wr_reg <= 1'b1;
                mem_addr_reg <= sp_reg;
                mem_wdata_reg <= (cmd_op == `CPS_OP_PSHA) ? acc_reg : hx_reg[15:8];
                sp_reg <= sp_down;
              end
              `CPS_OP_PULA, `CPS_OP_PULL_HI: begin
                pull_sel_reg <= (cmd_op == `CPS_OP_PULA) ? PL_ACC : PL_HIGH;
                pull_len_reg <= 3'h1;
                cnt_reg <= 3'h0;
                state_reg <= ST_PULL;
              end
              `CPS_OP_MASK_CLR: ccr_reg[`CPS_CCR_I] <= 1'b0;
              `CPS_OP_SEI: ccr_reg[`CPS_CCR_I] <= 1'b1;
              `CPS_OP_JMP: pc_reg <= hx_reg;
              `CPS_OP_FETCH: pc_reg <= pc_reg + 16'h0001;
              `CPS_OP_BRA: pc_reg <= pc_reg + 16'h0002 + {{8{cmd_data[7]}}, cmd_data};
              `CPS_OP_RET_INT: begin
                pull_sel_reg <= PL_FRAME;
                pull_len_reg <= 3'h5;
                cnt_reg <= 3'h0;
                state_reg <= ST_PULL;
              end
              `CPS_OP_TRAP: begin
                vec_base_reg <= `CPS_VEC_TRAP;
                cnt_reg <= 3'h0;
                state_reg <= ST_PUSH;
              end
              `CPS_OP_WAIT: begin
                ccr_reg[`CPS_CCR_I] <= 1'b0;
                stop_mode_reg <= 1'b0;
                state_reg <= ST_SLEEP;
              end
              `CPS_OP_STOP: begin
                ccr_reg[`CPS_CCR_I] <= 1'b0;
                stop_mode_reg <= 1'b1;
                state_reg <= ST_SLEEP;
              end
              default: begin
              end
            endcase
          end else if (brk_req && !brk_active_reg) begin
            brk_active_reg <= 1'b1;
            ir_load_reg <= 1'b1;
            ir_value_reg <= TRAP_OPCODE;
            vec_base_reg <= monitor_mode ? `CPS_VEC_TRAP_MON : `CPS_VEC_TRAP;
            cnt_reg <= 3'h0;
            state_reg <= ST_PUSH;
          end else if (req_any && !ccr_reg[`CPS_CCR_I]) begin
            vec_base_reg <= irq_vec;
            cnt_reg <= 3'h0;
            state_reg <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          mem_wr_reg <= 1'b1;
          mem_addr_reg <= sp_reg;
          sp_reg <= sp_down;
          case (cnt_reg)
            3'h0: mem_wdata_reg <= pc_reg[7:0];
            3'h1: mem_wdata_reg <= pc_reg[15:8];
            3'h2: mem_wdata_reg <= hx_reg[7:0];
            3'h3: mem_wdata_reg <= acc_reg;
            default: mem_wdata_reg <= ccr_view;
          endcase
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h4) begin
            state_reg <= ST_SETI;
          end
        end
        ST_SETI: begin
          mem_wr_reg <= 1'b0;
          ccr_reg[`CPS_CCR_I] <= 1'b1;
          cnt_reg <= 3'h0;
          state_reg <= ST_VECT;
        end
        ST_VECT: begin
          // Memory answers within the cycle that mem_rd is high
          case (cnt_reg)
            3'h0: begin
              mem_rd_reg <= 1'b1;
              mem_addr_reg <= vec_base_reg;
              cnt_reg <= 3'h1;
            end
            3'h1: begin
              pc_reg[15:8] <= mem_rdata;
              mem_addr_reg <= vec_base_reg + 16'h0001;
              cnt_reg <= 3'h2;
            end
            default: begin
              pc_reg[7:0] <= mem_rdata;
              mem_rd_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          endcase
        end
        ST_PULL: begin
          if (cnt_reg != pull_len_reg) begin
            mem_rd_reg <= 1'b1;
            mem_addr_reg <= sp_up;
            sp_reg <= sp_up;
          end else begin
            mem_rd_reg <= 1'b0;
            state_reg <= ST_IDLE;
            if (pull_sel_reg == PL_FRAME && brk_active_reg && !brk_req) begin
              brk_active_reg <= 1'b0;
            end
          end
          if (cnt_reg != 3'h0) begin
            if (pull_sel_reg == PL_ACC) begin
              acc_reg <= mem_rdata;
            end else if (pull_sel_reg == PL_HIGH) begin
              hx_reg[15:8] <= mem_rdata;
            end else begin
              case (cnt_reg)
                3'h1: ccr_reg <= mem_rdata | `CPS_CCR_ONES;
                3'h2: acc_reg <= mem_rdata;
                3'h3: hx_reg[7:0] <= mem_rdata;
                3'h4: pc_reg[15:8] <= mem_rdata;
                default: pc_reg[7:0] <= mem_rdata;
              endcase
            end
          end
          cnt_reg <= cnt_reg + 3'h1;
        end
        ST_SLEEP: begin
          // stop wakes on external pin only
          if (stop_mode_reg && ext_irq) begin
            stab_cnt_reg <= 32'h00000000;
            state_reg <= ST_STAB;
          end else if (!stop_mode_reg && req_any) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_STAB: begin
          stab_cnt_reg <= stab_cnt_reg + 32'h00000001;
          if (stab_cnt_reg >= STAB_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // core state is never placed on the memory address decode
  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign cpu_clk_en = (state_reg != ST_SLEEP) && (state_reg != ST_STAB);
  assign ir_load = ir_load_reg;
  assign ir_value = ir_value_reg;
endmodule
`default_nettype wire

// ### verif/cps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module cps_monitor #(
  parameter [7:0] TRAP_OPCODE = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Memory bus and core control
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic cpu_clk_en,
  input wire logic ir_load,
  input wire logic [7:0] ir_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  AST_ACK_WAIT: assert property (req |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UNMAPPED: assert property (req && !wb_we_i && wb_adr_i > 5'h18 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FLAG_ONES: assert property (req && !wb_we_i && wb_adr_i == `CPS_ADR_CCR |=> wb_dat_o[6:5] == 2'b11)
    else $error("flag bits 6 5 not one");
  AST_RESET_VEC: assert property ($rose(rst_b) |=> mem_rd && mem_addr == 16'hFFFE ##1 mem_addr == 16'hFFFF)
    else $error("reset vector fetch wrong");
  AST_PUSH_DOWN: assert property (mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("push not descending");
  // Five bytes only: index high byte stays off the stack
  AST_ENTRY_FRAME: assert property ($rose(mem_wr) ##1 mem_wr |-> mem_wr [*4] ##1 !mem_wr ##1 mem_rd)
    else $error("entry frame wrong");
  AST_TRAP_CODE: assert property (ir_load |-> ir_value == TRAP_OPCODE)
    else $error("trap opcode wrong");
  AST_TRAP_PULSE: assert property (ir_load |=> !ir_load)
    else $error("trap load too long");
  AST_SLEEP_QUIET: assert property (!cpu_clk_en |-> !mem_rd && !mem_wr)
    else $error("bus busy while clock stopped");
  COV_ENTRY: cover property ($rose(mem_wr) ##1 mem_wr [*4]);
  COV_TRAP: cover property (ir_load);
  COV_SLEEP: cover property ($fell(cpu_clk_en));
endmodule
`default_nettype wire

// ### verif/cps_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cps_mem_model (
  // Clock
  input wire logic clk,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    mem[16'hFFFE] = 8'h12;
    mem[16'hFFFF] = 8'h34;
    mem[16'hFFFA] = 8'h80;
    mem[16'hFFF8] = 8'h81;
    mem[16'hFFFC] = 8'h90;
    mem[16'hFEFC] = 8'hA0;
    last_reg = 8'h00;
  end
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last_reg <= mem_rdata;
    end
  end
  // Idle bus shows a changed value, never a stale copy
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.vh"
module tb_top;
  logic clk, rst_b, cyc, stb, we, ext_b, brk, mon;
  logic [4:0] adr;
  logic [3:0] sel, irq;
  logic [31:0] wdat, q, wb_dat_o;
  logic wb_ack_o, mem_rd, mem_wr, cpu_clk_en, ir_load;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, ir_value;
  int fail_count = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  cps_core #(.STAB_CYCLES(8), .TRAP_OPCODE(8'h3C)) DUT (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .irq_req(irq), .ext_irq_b(ext_b), .brk_req(brk), .monitor_mode(mon),
    .cpu_clk_en(cpu_clk_en), .ir_load(ir_load), .ir_value(ir_value));
  cps_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      fail_count++;
      $display("CHECK FAILED wait expected done seen timeout");
      stop_test();
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 60);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 4'hF, 32'h0);
    chk(nm, e, q & m);
  endtask
  // Poll until two reads in a row see the core idle
  task automatic cmd(input logic [4:0] op, input logic [7:0] v, input bit poll);
    int n;
    int z;
    n = 0;
    z = 0;
    wb(1'b1, `CPS_ADR_CMD, 4'hF, {19'h0, op, v});
    while (poll && z < 2 && n < 60) begin
      wb(1'b0, `CPS_ADR_STAT, 4'hF, 32'h0);
      z = (q[0] === 1'b0) ? z + 1 : 0;
      n++;
    end
    tmo(n);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic alu(input logic [4:0] op, input logic [7:0] v, input logic [7:0] ea, input logic [7:0] ef,
                     input logic [7:0] m);
    cmd(op, v, 1'b1);
    rd("acc", `CPS_ADR_ACC, {24'h0, ea}, '1);
    rd("flags", `CPS_ADR_CCR, {24'h0, ef}, {24'h0, m});
  endtask
  task automatic t_reset;
    rd("sp", `CPS_ADR_SP, 32'h00FF, '1);
    rd("pc", `CPS_ADR_PC, 32'h1234, '1);
    rd("flags", `CPS_ADR_CCR, 32'h68, '1);
    wb(1'b1, 5'h1C, 4'hF, 32'hFF);
    rd("unmapped", 5'h1C, 32'h0, '1);
    wb(1'b1, `CPS_ADR_CMD, 4'h1, {19'h0, `CPS_OP_LDA, 8'h77});
    rd("acc", `CPS_ADR_ACC, 32'h0, '1);
    $display("reset test done");
  endtask
  task automatic t_alu;
    alu(`CPS_OP_LDA, 8'h7F, 8'h7F, 8'h60, 8'hE6);
    alu(`CPS_OP_ADD, 8'h01, 8'h80, 8'hFC, 8'hFF);
    alu(`CPS_OP_ADD, 8'h80, 8'h00, 8'hEB, 8'hFF);
    alu(`CPS_OP_SUB, 8'h01, 8'hFF, 8'h6D, 8'hEF);
    alu(`CPS_OP_ADC, 8'h00, 8'h00, 8'h7B, 8'hFF);
    alu(`CPS_OP_LDA, 8'h81, 8'h81, 8'h64, 8'hE6);
    alu(`CPS_OP_ASL, 8'h00, 8'h02, 8'hE1, 8'hE7);
    alu(`CPS_OP_SBC, 8'h01, 8'h00, 8'h6A, 8'hEF);
    alu(`CPS_OP_ORA, 8'hA5, 8'hA5, 8'h64, 8'hE6);
    alu(`CPS_OP_AND, 8'h0F, 8'h05, 8'h60, 8'hE6);
    alu(`CPS_OP_EOR, 8'h05, 8'h00, 8'h62, 8'hE6);
    $display("alu test done");
  endtask
  task automatic t_stack;
    cmd(`CPS_OP_LDX, 8'h34, 1'b1);
    cmd(`CPS_OP_LDH, 8'h12, 1'b1);
    rd("index", `CPS_ADR_HX, 32'h1234, '1);
    cmd(`CPS_OP_LDA, 8'h5A, 1'b1);
    cmd(`CPS_OP_PSHA, 8'h00, 1'b1);
    cmd(`CPS_OP_PUSH_HI, 8'h00, 1'b1);
    chk("pushed", 32'h5A12, {16'h0, u_mem.mem[16'h00FF], u_mem.mem[16'h00FE]});
    rd("sp", `CPS_ADR_SP, 32'h00FD, '1);
    cmd(`CPS_OP_PULA, 8'h00, 1'b1);
    rd("acc", `CPS_ADR_ACC, 32'h12, '1);
    cmd(`CPS_OP_PULL_HI, 8'h00, 1'b1);
    cmd(`CPS_OP_PULL_HI, 8'h00, 1'b1);
    rd("sp", `CPS_ADR_SP, 32'h0100, '1);
    cmd(`CPS_OP_STK_LOW, 8'h00, 1'b1);
    rd("sp", `CPS_ADR_SP, 32'h01FF, '1);
    cmd(`CPS_OP_JMP, 8'h00, 1'b1);
    rd("pc", `CPS_ADR_PC, 32'h0034, '1);
    cmd(`CPS_OP_FETCH, 8'h00, 1'b1);
    cmd(`CPS_OP_BRA, 8'hFE, 1'b1);
    rd("pc", `CPS_ADR_PC, 32'h0035, '1);
    $display("stack test done");
  endtask
  task automatic t_irq;
    irq <= 4'b0011;
    repeat (10) @(posedge clk);
    rd("pc", `CPS_ADR_PC, 32'h0035, '1);
    cmd(`CPS_OP_MASK_CLR, 8'h00, 1'b1);
    rd("pc", `CPS_ADR_PC, 32'h8100, '1);
    rd("flags", `CPS_ADR_CCR, 32'h08, 32'h08);
    rd("sp", `CPS_ADR_SP, 32'h01FA, '1);
    chk("stacked mask", 32'h0, {31'h0, u_mem.mem[16'h01FB][3]});
    chk("stacked pc", 32'h0035, {16'h0, u_mem.mem[16'h01FE], u_mem.mem[16'h01FF]});
    irq <= 4'b0000;
    cmd(`CPS_OP_RET_INT, 8'h00, 1'b1);
    rd("pc", `CPS_ADR_PC, 32'h0035, '1);
    rd("flags", `CPS_ADR_CCR, 32'h00, 32'h08);
    $display("interrupt test done");
  endtask
  task automatic t_wait;
    cmd(`CPS_OP_SEI, 8'h00, 1'b1);
    cmd(`CPS_OP_WAIT, 8'h00, 1'b0);
    repeat (4) @(posedge clk);
    chk("clock enable", 32'h0, {31'h0, cpu_clk_en});
    rd("flags", `CPS_ADR_CCR, 32'h00, 32'h08);
    irq <= 4'b0001;
    repeat (4) @(posedge clk);
    cmd(5'h1F, 8'h00, 1'b1);
    irq <= 4'b0000;
    chk("clock enable", 32'h1, {31'h0, cpu_clk_en});
    rd("pc", `CPS_ADR_PC, 32'h8100, '1);
    cmd(`CPS_OP_RET_INT, 8'h00, 1'b1);
    rd("flags", `CPS_ADR_CCR, 32'h00, 32'h08);
    $display("wait test done");
  endtask
  task automatic t_stop;
    int n;
    n = 0;
    cmd(`CPS_OP_SEI, 8'h00, 1'b1);
    cmd(`CPS_OP_STOP, 8'h00, 1'b0);
    irq <= 4'b0001;
    repeat (20) @(posedge clk);
    chk("clock enable", 32'h0, {31'h0, cpu_clk_en});
    rd("flags", `CPS_ADR_CCR, 32'h00, 32'h08);
    irq <= 4'b0000;
    ext_b <= 1'b0;
    while (cpu_clk_en !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
    chk("restart delay", 32'h1, {31'h0, n >= 8 && n <= 14});
    cmd(5'h1F, 8'h00, 1'b1);
    ext_b <= 1'b1;
    rd("pc", `CPS_ADR_PC, 32'h8000, '1);
    cmd(`CPS_OP_STOP, 8'h00, 1'b0);
    repeat (4) @(posedge clk);
    do_reset();
    rd("flags", `CPS_ADR_CCR, 32'h68, '1);
    chk("clock enable", 32'h1, {31'h0, cpu_clk_en});
    $display("stop test done");
  endtask
  task automatic t_break;
    int n;
    for (int m = 0; m < 2; m++) begin
      n = 0;
      mon <= m[0];
      brk <= 1'b1;
      while (ir_load !== 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
      end
      tmo(n);
      chk("trap opcode", 32'h3C, {24'h0, ir_value});
      brk <= 1'b0;
      cmd(5'h1F, 8'h00, 1'b1);
      rd("pc", `CPS_ADR_PC, m ? 32'hA000 : 32'h9000, '1);
      rd("break", `CPS_ADR_STAT, 32'h08, 32'h08);
      cmd(`CPS_OP_RET_INT, 8'h00, 1'b1);
      rd("break", `CPS_ADR_STAT, 32'h00, 32'h08);
    end
    // Software trap shares the vector but is no break
    cmd(`CPS_OP_TRAP, 8'h00, 1'b1);
    rd("pc", `CPS_ADR_PC, 32'h9000, '1);
    rd("break", `CPS_ADR_STAT, 32'h00, 32'h08);
    cmd(`CPS_OP_RET_INT, 8'h00, 1'b1);
    $display("break test done");
  endtask
  initial begin
    clk = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'hF;
    wdat = 32'h0;
    irq = 4'h0;
    ext_b = 1'b1;
    brk = 1'b0;
    mon = 1'b0;
    rst_b = 1'b0;
    do_reset();
    t_reset();
    t_alu();
    t_stack();
    t_irq();
    t_wait();
    t_stop();
    t_break();
    stop_test();
  end
endmodule
bind cps_core cps_monitor #(.TRAP_OPCODE(TRAP_OPCODE)) u_mon (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .cpu_clk_en(cpu_clk_en), .ir_load(ir_load),
  .ir_value(ir_value));
`default_nettype wire
